// *** rtl/phy_mgmt_pkg.sv ***
// phy_mgmt_pkg: shared constants for the phy management link
// assumes a 200 MHz aclk on both ends of the link
package phy_mgmt_pkg;
  localparam logic [4:0]  PHY_ADDR       = 5'h01;
  localparam logic [1:0]  OP_RD          = 2'h2;
  localparam logic [1:0]  OP_WR          = 2'h1;
  localparam logic [4:0]  REG_BMCR       = 5'h00;
  localparam logic [4:0]  REG_BMSR       = 5'h01;
  localparam logic [4:0]  REG_ADV        = 5'h04;
  localparam logic [4:0]  REG_GADV       = 5'h09;
  localparam logic [4:0]  REG_LEG_LINK   = 5'h11;
  localparam logic [4:0]  REG_IER        = 5'h12;
  localparam logic [4:0]  REG_LEG_INT    = 5'h13;
  localparam logic [4:0]  REG_CFG_DONE   = 5'h14;
  localparam logic [4:0]  REG_SKEW       = 5'h18;
  localparam logic [4:0]  REG_PG_LINK    = 5'h1a;
  localparam logic [4:0]  REG_PG_INT     = 5'h1d;
  localparam logic [4:0]  REG_PAGE       = 5'h1f;
  localparam logic [15:0] PAGE_IER       = 16'h0a42;
  localparam logic [15:0] PAGE_LINK      = 16'h0a43;
  localparam logic [15:0] PAGE_CFG       = 16'h0a46;
  localparam int          BMCR_AN_BIT    = 12;
  localparam int          BMSR_LINK_BIT  = 2;
  localparam int          BMSR_AN_BIT    = 5;
  localparam int          ADV_10F_BIT    = 6;
  localparam int          ADV_100F_BIT   = 8;
  localparam int          GADV_1000F_BIT = 9;
  localparam int          CFG_DONE_BIT   = 1;
  localparam int          INT_LINK_BIT   = 0;
  localparam int          INT_AN_BIT     = 1;
  localparam int          INT_READY_BIT  = 2;
  localparam logic [15:0] BMCR_RST       = 16'h1000;
  localparam logic [15:0] BMSR_RST       = 16'h7949;
  localparam logic [15:0] ADV_RST        = 16'h0141;
  localparam logic [15:0] GADV_RST       = 16'h0200;
  localparam logic [15:0] SKEW_RST       = 16'h0003;
  localparam logic [15:0] IER_RST_NEW    = 16'h0004;
  localparam logic [15:0] IER_RST_OLD    = 16'h0007;
  localparam int unsigned CLK_HZ         = 200_000_000;
  localparam int unsigned CLK_PS         = 5000;
  localparam int unsigned SKEW_PS        = 2000;
  localparam int unsigned SKEW_CYC = (SKEW_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned READY_NEW_MS   = 100;
  localparam int unsigned READY_OLD_MS   = 20;
  localparam int unsigned READY_NEW_CYC  = CLK_HZ / 1000 * READY_NEW_MS;
  localparam int unsigned READY_OLD_CYC  = CLK_HZ / 1000 * READY_OLD_MS;
  localparam int unsigned EEE_ON_MS      = 400;
  localparam int unsigned EEE_OFF_MS     = 2000;
  localparam int unsigned EEE_ON_CYC     = CLK_HZ / 1000 * EEE_ON_MS;
  localparam int unsigned EEE_OFF_CYC    = CLK_HZ / 1000 * EEE_OFF_MS;
  localparam int unsigned ACT_MS         = 50;
  localparam int unsigned ACT_CYC        = CLK_HZ / 1000 * ACT_MS;
  localparam int unsigned MDC_MAX_HZ     = 2_500_000;
  localparam logic [15:0] MDC_HALF = 16'(CLK_HZ / (2 * MDC_MAX_HZ));
  // station address locations in serial flash, read by software
  localparam logic [7:0]  OTP_MAC_LO     = 8'h20;
  localparam logic [7:0]  OTP_MAC_HI     = 8'h25;
  localparam logic [7:0]  SEC_RD_CMD     = 8'h48;
  localparam logic [23:0] SEC_MAC_LO     = 24'h00_1000;
  localparam logic [23:0] SEC_MAC_HI     = 24'h00_1005;
  localparam logic [7:0]  A_CTRL         = 8'h00;
  localparam logic [7:0]  A_CMD          = 8'h04;
  localparam logic [7:0]  A_STATUS       = 8'h08;
  localparam logic [7:0]  A_IRQ_STAT     = 8'h0c;
  localparam logic [7:0]  A_IRQ_MASK     = 8'h10;
  localparam int          CTRL_HWRST_BIT = 0;
  localparam int          CTRL_WAIT_BIT  = 1;
  localparam int          CMD_WR_BIT     = 8;
  localparam int          IRQ_DONE_BIT   = 0;
  localparam int          IRQ_PHY_BIT    = 1;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

// *** rtl/phy_link_if.sv ***
// phy_link_if: management pins between controller and phy
// assumes mdio has a pull-up: undriven reads as one
`timescale 1ns/1ps
interface phy_link_if;
  logic mdc;
  logic mdio_h_o;
  logic mdio_h_oe;
  logic mdio_d_o;
  logic mdio_d_oe;
  logic mdio;
  logic phy_interrupt_n;
  logic phy_hw_reset_n;
  logic ref_clock_out;
  assign mdio = !(mdio_h_oe && !mdio_h_o) && !(mdio_d_oe && !mdio_d_o);
  modport host (output mdc, mdio_h_o, mdio_h_oe, phy_hw_reset_n,
                input  mdio, phy_interrupt_n, ref_clock_out);
  modport phy  (input  mdc, mdio, phy_hw_reset_n,
                output mdio_d_o, mdio_d_oe, phy_interrupt_n,
                ref_clock_out);
endinterface

// *** rtl/sync_edge.sv ***
// sync_edge: two-flop synchroniser with edge detect
// assumes d is asynchronous to aclk
`timescale 1ns/1ps
module sync_edge #(
  parameter bit INIT = 1'b0
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic d,
  output logic      q,
  output logic      rise,
  output logic      fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_t;
  sync_t s;
  sync_t n;
  always_comb begin
    n = '{s1: d, s2: s.s1, s3: s.s2};
    if (!aresetn) begin
      n = {3{INIT}};
    end
  end
  always_ff @(posedge aclk) begin
    s <= n;
  end
  // only s2 onward is read; s1 may be metastable
  assign q    = s.s2;
  assign rise = s.s2 && !s.s3;
  assign fall = !s.s2 && s.s3;
endmodule // sync_edge

// *** rtl/phy_device.sv ***
// phy_device: management side of the ethernet phy
// assumes the controller drives mdc and reset; user ports on aclk
`timescale 1ns/1ps
module phy_device #(
  parameter bit          NEWER       = 1'b1,
  parameter int unsigned READY_CYC   = NEWER ? phy_mgmt_pkg::READY_NEW_CYC
                                             : phy_mgmt_pkg::READY_OLD_CYC,
  parameter int unsigned EEE_ON_CYC  = phy_mgmt_pkg::EEE_ON_CYC,
  parameter int unsigned EEE_OFF_CYC = phy_mgmt_pkg::EEE_OFF_CYC,
  parameter int unsigned ACT_CYC     = phy_mgmt_pkg::ACT_CYC
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  phy_link_if.phy               ifc,
  input  wire logic             partner_present,
  input  wire logic [2:0]       partner_ability,
  input  wire logic             traffic,
  input  wire logic             eee_mode,
  input  wire logic [1:0][5:0]  lane_in,
  output logic      [1:0][5:0]  lane_out,
  output logic      [2:0]       led,
  output logic                  link_up
);
  import phy_mgmt_pkg::*;
  typedef enum logic [1:0] {S_IDLE, S_HDR, S_RD, S_WR} mst_t;
  typedef struct packed {
    mst_t                      st;
    logic [5:0]                bits;
    logic [12:0]               hdr;
    logic [15:0]               sh;
    logic                      md_o;
    logic                      md_oe;
    logic [15:0]               bmcr;
    logic [15:0]               adv;
    logic [15:0]               gadv;
    logic [15:0]               skew;
    logic [15:0]               page;
    logic [15:0]               ier;
    logic [15:0]               isr;
    logic                      ready;
    logic [31:0]               rcnt;
    logic [31:0]               acnt;
    logic                      aph;
    logic [31:0]               ecnt;
    logic                      link;
    logic [1:0]                spd;
    logic [2:0]                led;
    logic                      irq_n;
    logic                      refclk;
    logic [SKEW_CYC-1:0][1:0]  cdl;
    logic [1:0][5:0]           lo;
  } dev_t;
  dev_t s;
  dev_t n;
  logic mdc_rise;
  logic mdc_fall;
  logic din;
  logic hrst_n;

  sync_edge #(.INIT(1'b0)) u_mdc (.aclk(aclk), .aresetn(aresetn),
    .d(ifc.mdc), .q(), .rise(mdc_rise), .fall(mdc_fall));
  sync_edge #(.INIT(1'b1)) u_mdio (.aclk(aclk), .aresetn(aresetn),
    .d(ifc.mdio), .q(din), .rise(), .fall());
  sync_edge #(.INIT(1'b0)) u_rst (.aclk(aclk), .aresetn(aresetn),
    .d(ifc.phy_hw_reset_n), .q(hrst_n), .rise(), .fall());

  function automatic logic [1:0] best_speed(input logic [2:0] c);
    return c[2] ? 2'd2 : (c[1] ? 2'd1 : 2'd0);
  endfunction

  function automatic logic isr_hit(input logic [4:0] r,
                                   input logic [15:0] pg);
    return NEWER ? (r == REG_PG_INT && pg == PAGE_LINK)
                 : (r == REG_LEG_INT);
  endfunction

  function automatic logic [15:0] rd_reg(input dev_t v,
                                         input logic [4:0] r);
    logic [15:0] lst;
    logic        pg;
    lst = {10'h000, v.spd, v.link, v.link, 2'b00};
    pg  = (v.page == PAGE_LINK);
    rd_reg = 16'h0000;
    case (r)
      REG_BMCR:     rd_reg = v.bmcr;
      REG_BMSR: begin
        rd_reg = BMSR_RST;
        rd_reg[BMSR_LINK_BIT] = v.link;
        rd_reg[BMSR_AN_BIT] = v.link;
      end
      REG_ADV:      rd_reg = v.adv;
      REG_GADV:     rd_reg = v.gadv;
      REG_SKEW:     rd_reg = v.skew;
      REG_PAGE:     rd_reg = v.page;
      REG_LEG_LINK: rd_reg = NEWER ? 16'h0000 : lst;
      REG_PG_LINK:  rd_reg = (NEWER && pg) ? lst : 16'h0000;
      REG_IER:      rd_reg = (!NEWER || v.page == PAGE_IER) ? v.ier : 16'h0000;
      default:      rd_reg = isr_hit(r, v.page) ? v.isr : 16'h0000;
    endcase
  endfunction

  always_comb begin
    logic [12:0] h;
    logic        perm;
    logic        clr;
    logic [15:0] ev;
    logic [15:0] wd;
    logic [2:0]  com;
    n    = s;
    h    = {s.hdr[11:0], din};
    perm = 1'b0;
    clr  = 1'b0;
    ev   = 16'h0000;
    wd   = {s.sh[14:0], din};
    // negotiate the highest speed both sides advertise
    com  = {s.gadv[GADV_1000F_BIT], s.adv[ADV_100F_BIT], s.adv[ADV_10F_BIT]}
           & partner_ability & {3{s.bmcr[BMCR_AN_BIT]}};
    n.link = partner_present && (|com);
    n.spd  = best_speed(com);
    ev[INT_LINK_BIT] = n.link != s.link;
    ev[INT_AN_BIT]   = n.link && !s.link;
    if (!s.ready) begin
      n.rcnt = s.rcnt + 32'd1;
      n.ready = (s.rcnt == READY_CYC - 1);
    end
    case (s.st)
      S_IDLE: if (mdc_rise) begin
        if (din) begin
          n.bits = (s.bits == 6'd32) ? s.bits : s.bits + 6'd1;
        end else if (s.bits == 6'd32) begin
          n.st = S_HDR;
          n.bits = 6'd0;
        end else begin
          n.bits = 6'd0;
        end
      end
      S_HDR: if (mdc_rise) begin
        n.hdr = h;
        n.bits = s.bits + 6'd1;
        if (s.bits == 6'd12) begin
          // before ready, only the page and config-done writes pass, and none on the older phy
          perm = s.ready || (NEWER && h[11:10] == OP_WR &&
                 (h[4:0] == REG_PAGE || h[4:0] == REG_CFG_DONE));
          n.bits = 6'd0;
          n.st = S_IDLE;
          if (h[12] && h[9:5] == PHY_ADDR && perm) begin
            if (h[11:10] == OP_RD) begin
              n.st = S_RD;
              n.sh = rd_reg(s, h[4:0]);
              clr = isr_hit(h[4:0], s.page);
            end else if (h[11:10] == OP_WR) begin
              n.st = S_WR;
            end
          end
        end
      end
      S_RD: if (mdc_fall) begin
        n.bits = s.bits + 6'd1;
        if (s.bits == 6'd1) begin
          n.md_oe = 1'b1;
          n.md_o = 1'b0;
        end else if (s.bits == 6'd18) begin
          n.md_oe = 1'b0;
          n.st = S_IDLE;
          n.bits = 6'd0;
        end else if (s.bits != 6'd0) begin
          n.md_o = s.sh[15];
          n.sh = {s.sh[14:0], 1'b0};
        end
      end
      S_WR: if (mdc_rise) begin
        n.sh = wd;
        n.bits = s.bits + 6'd1;
        if (s.bits == 6'd17) begin
          n.st = S_IDLE;
          n.bits = 6'd0;
          case (s.hdr[4:0])
            REG_BMCR: n.bmcr = wd;
            REG_ADV:  n.adv = wd;
            REG_GADV: n.gadv = wd;
            REG_SKEW: n.skew = wd;
            REG_PAGE: n.page = wd;
            REG_IER:  if (!NEWER || s.page == PAGE_IER) n.ier = wd;
            REG_CFG_DONE: if (NEWER && s.page == PAGE_CFG &&
                              wd[CFG_DONE_BIT]) n.ready = 1'b1;
            default: ;
          endcase
        end
      end
      default: n.st = S_IDLE;
    endcase
    ev[INT_READY_BIT] = NEWER && n.ready && !s.ready;
    // a new event wins over a clear-on-read in the same cycle
    n.isr = (clr ? 16'h0000 : s.isr) | ev;
    n.irq_n = ~|(n.isr & n.ier);
    n.acnt = (s.acnt >= ACT_CYC - 1) ? 32'd0 : s.acnt + 32'd1;
    n.aph = (s.acnt >= ACT_CYC - 1) ? !s.aph : s.aph;
    n.ecnt = (s.ecnt >= EEE_ON_CYC + EEE_OFF_CYC - 1) ? 32'd0
             : s.ecnt + 32'd1;
    if (NEWER) begin
      for (int i = 0; i < 3; i++) begin
        n.led[i] = s.link && s.spd == 2'(i) && (!traffic || s.aph);
      end
    end else begin
      n.led[0] = s.link && (!eee_mode || s.ecnt < EEE_ON_CYC);
      n.led[1] = traffic && s.aph;
      n.led[2] = 1'b0;
    end
    // 100 MHz stand-in: the 200 MHz core clock cannot give 125 MHz
    n.refclk = !s.refclk;
    // delay only the clock bit of each lane; data pass one flop
    for (int l = 0; l < 2; l++) begin
      n.cdl[0][l] = lane_in[l][5];
      n.lo[l] = lane_in[l];
      if (s.skew[l]) n.lo[l][5] = s.cdl[SKEW_CYC-1][l];
    end
    for (int k = 1; k < SKEW_CYC; k++) begin
      n.cdl[k] = s.cdl[k-1];
    end
    if (!aresetn || !hrst_n) begin
      n = '0;
      n.st = S_IDLE;
      n.bmcr = BMCR_RST;
      n.adv = ADV_RST;
      n.gadv = GADV_RST;
      n.skew = SKEW_RST;
      n.ier = NEWER ? IER_RST_NEW : IER_RST_OLD;
      n.irq_n = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    s <= n;
  end

  assign ifc.mdio_d_o        = s.md_o;
  assign ifc.mdio_d_oe       = s.md_oe;
  assign ifc.phy_interrupt_n = s.irq_n;
  assign ifc.ref_clock_out   = s.refclk;
  assign lane_out            = s.lo;
  assign led                 = s.led;
  assign link_up             = s.link;
endmodule // phy_device

// *** rtl/mdio_host.sv ***
// mdio_host: axi4-lite controlled management master for the phy
// assumes software polls status or uses irq; one frame at a time
`timescale 1ns/1ps
module mdio_host (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  phy_link_if.host         ifc,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq
);
  import phy_mgmt_pkg::*;
  typedef enum logic {H_IDLE, H_RUN} hst_t;
  typedef struct packed {
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [31:0] cmd;
    logic        pend;
    logic [15:0] rd_val;
    logic [1:0]  istat;
    logic [1:0]  imask;
    logic        irq;
    logic        ready_seen;
    hst_t        st;
    logic [15:0] div;
    logic        mdc;
    logic [63:0] sh;
    logic [5:0]  bitn;
    logic        rd;
    logic        md_o;
    logic        md_oe;
  } host_t;
  host_t s;
  host_t n;
  logic mdin;
  logic int_fall;

  sync_edge #(.INIT(1'b1)) u_mdio (.aclk(aclk), .aresetn(aresetn),
    .d(ifc.mdio), .q(mdin), .rise(), .fall());
  sync_edge #(.INIT(1'b1)) u_int (.aclk(aclk), .aresetn(aresetn),
    .d(ifc.phy_interrupt_n), .q(), .rise(), .fall(int_fall));

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0]  b);
    for (int i = 0; i < 4; i++) begin
      if (b[i]) o[8*i +: 8] = d[8*i +: 8];
    end
    return o;
  endfunction

  always_comb begin
    logic        wr;
    logic        gate;
    logic [1:0]  ev;
    n    = s;
    ev   = 2'b00;
    wr   = s.cmd[CMD_WR_BIT];
    // with wait enabled, only page and config-done writes go early
    gate = !s.ctrl[CTRL_WAIT_BIT] || s.ready_seen || (wr &&
           (s.cmd[4:0] == REG_PAGE || s.cmd[4:0] == REG_CFG_DONE));
    if (s_axi_awvalid && s.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) n.bvalid = 1'b0;
    if (s.aw_got && s.w_got && !s.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (s.awaddr)
        A_CTRL:     n.ctrl = merge(s.ctrl, s.wdata, s.wstrb);
        A_CMD:      if (!s.pend && s.st == H_IDLE) begin
          n.cmd = merge(s.cmd, s.wdata, s.wstrb);
          n.pend = 1'b1;
        end
        A_IRQ_STAT: n.istat = s.istat & ~s.wdata[1:0];
        A_IRQ_MASK: n.imask = s.wdata[1:0];
        default:    n.bresp = RESP_SLVERR;
      endcase
    end
    if (s.rvalid && s_axi_rready) n.rvalid = 1'b0;
    if (s_axi_arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      case (s_axi_araddr)
        A_CTRL:     n.rdata = s.ctrl;
        A_CMD:      n.rdata = s.cmd;
        A_STATUS:   n.rdata = {s.rd_val, 14'h0000, s.ready_seen,
                               s.pend || s.st == H_RUN};
        A_IRQ_STAT: n.rdata = {30'h0000_0000, s.istat};
        A_IRQ_MASK: n.rdata = {30'h0000_0000, s.imask};
        default: begin
          n.rdata = 32'h0000_0000;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;
    n.arready = !n.rvalid;
    case (s.st)
      H_IDLE: if (s.pend && gate) begin
        n.pend = 1'b0;
        n.st = H_RUN;
        n.rd = !wr;
        n.sh = {32'hFFFF_FFFF, 2'b01, wr ? OP_WR : OP_RD, PHY_ADDR,
                s.cmd[4:0], 2'b10, s.cmd[31:16]};
        n.bitn = 6'd0;
        n.div = 16'h0000;
        n.mdc = 1'b0;
        n.md_o = 1'b1;
        n.md_oe = 1'b1;
      end
      H_RUN: begin
        n.div = s.div + 16'h0001;
        if (s.div == MDC_HALF - 16'h0001) begin
          n.div = 16'h0000;
          n.mdc = !s.mdc;
          if (!s.mdc) begin
            if (s.rd && s.bitn >= 6'd48) n.rd_val = {s.rd_val[14:0], mdin};
          end else if (s.bitn == 6'd63) begin
            // one more fall: the phy samples bit 63 before we let go
            n.st = H_IDLE;
            n.md_oe = 1'b0;
            ev[IRQ_DONE_BIT] = 1'b1;
          end else begin
            n.bitn = s.bitn + 6'd1;
            n.sh = {s.sh[62:0], 1'b0};
            n.md_o = s.sh[62];
            n.md_oe = !(s.rd && s.bitn >= 6'd45);
          end
        end
      end
      default: n.st = H_IDLE;
    endcase
    ev[IRQ_PHY_BIT] = int_fall;
    if (int_fall) n.ready_seen = 1'b1;
    if (!s.ctrl[CTRL_HWRST_BIT]) n.ready_seen = 1'b0;
    // an event wins over a write-one-to-clear in the same cycle
    n.istat = n.istat | ev;
    n.irq = |(n.istat & n.imask);
    if (!aresetn) begin
      n = '0;
      n.st = H_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    s <= n;
  end

  assign ifc.mdc            = s.mdc;
  assign ifc.mdio_h_o       = s.md_o;
  assign ifc.mdio_h_oe      = s.md_oe;
  assign ifc.phy_hw_reset_n = s.ctrl[CTRL_HWRST_BIT];
  assign s_axi_awready      = s.awready;
  assign s_axi_wready       = s.wready;
  assign s_axi_bresp        = s.bresp;
  assign s_axi_bvalid       = s.bvalid;
  assign s_axi_arready      = s.arready;
  assign s_axi_rdata        = s.rdata;
  assign s_axi_rresp        = s.rresp;
  assign s_axi_rvalid       = s.rvalid;
  assign irq                = s.irq;
endmodule // mdio_host

// *** verification/phy_mgmt_props.sv ***
// phy_mgmt_props: checks on the management wires between both ends
// assumes one aclk domain and a synchronous active-low aresetn
`timescale 1ns/1ps
module phy_mgmt_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mdc,
  input wire logic mdio_h_o,
  input wire logic mdio_h_oe,
  input wire logic mdio_d_oe,
  input wire logic phy_interrupt_n,
  input wire logic phy_hw_reset_n,
  input wire logic ref_clock_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // five cycles cover the reset synchroniser lag of the phy
  a_refclk_held_reset: assert property (!phy_hw_reset_n [*5] |-> !ref_clock_out)
    else $error("reference clock runs in reset");
  a_refclk_toggles: assert property (phy_hw_reset_n [*8] |-> ref_clock_out != $past(ref_clock_out))
    else $error("reference clock stuck");
  a_irq_idle_reset: assert property (!phy_hw_reset_n [*5] |-> phy_interrupt_n)
    else $error("interrupt low in reset");
  a_phy_quiet_reset: assert property (!phy_hw_reset_n [*5] |-> !mdio_d_oe)
    else $error("phy drives mdio in reset");
  a_no_drive_clash: assert property (!(mdio_h_oe && mdio_d_oe))
    else $error("both ends drive mdio");
  a_host_shift_low: assert property ($changed(mdio_h_o) |-> !mdc)
    else $error("host data moved with mdc high");
  a_phy_turn_low: assert property ($changed(mdio_d_oe) |-> !mdc)
    else $error("phy turned mdio with mdc high");
  a_mdc_high_hold: assert property ($rose(mdc) |-> mdc [*8])
    else $error("mdc high phase too short");
  a_ready_after_reset: assert property ($fell(phy_interrupt_n) |-> $past(phy_hw_reset_n, 8))
    else $error("ready signalled too early");
  cover property ($fell(phy_interrupt_n));
  cover property ($rose(mdio_d_oe));
  cover property ($fell(mdc));
endmodule // phy_mgmt_props

// *** verification/ethernet_phy_bringup_management_bench.sv ***
// bench: host controller and phy joined over the management link
// assumes software access over axi4-lite only
`timescale 1ns/1ps
module ethernet_phy_bringup_management_bench;
  import phy_mgmt_pkg::*;
  logic             aclk = 1'b0, aresetn = 1'b0, irq, link_up;
  logic [7:0]       awaddr = 8'h0, araddr = 8'h0;
  logic [31:0]      wdata = 32'h0, rdata, rdv;
  logic [1:0]       bresp, rresp, rsp;
  logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic             arvalid = 1'b0, rready = 1'b0, pp = 1'b1, trf = 1'b0;
  logic             awready, wready, bvalid, arready, rvalid;
  logic [1:0][5:0]  lane_in = '0;
  logic [2:0]       led, abil = 3'b111;
  logic             eee = 1'b0;
  int               n_errors = 0, total_checks = 0;
  phy_link_if link ();
  // short counts keep the ready window and blink periods brief
  phy_device #(.READY_CYC(2000), .EEE_ON_CYC(40), .EEE_OFF_CYC(200),
    .ACT_CYC(20)) u_phy_device (.aclk(aclk), .aresetn(aresetn),
    .ifc(link.phy), .partner_present(pp), .partner_ability(abil),
    .traffic(trf), .eee_mode(eee), .lane_in(lane_in), .lane_out(),
    .led(led), .link_up(link_up));
  mdio_host u_mdio_host (.aclk(aclk), .aresetn(aresetn), .ifc(link.host),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
  phy_mgmt_props u_phy_mgmt_props (.aclk(aclk), .aresetn(aresetn),
    .mdc(link.mdc), .mdio_h_o(link.mdio_h_o), .mdio_h_oe(link.mdio_h_oe),
    .mdio_d_oe(link.mdio_d_oe), .phy_interrupt_n(link.phy_interrupt_n),
    .phy_hw_reset_n(link.phy_hw_reset_n),
    .ref_clock_out(link.ref_clock_out));
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) lane_in <= ~lane_in;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // handshakes are judged at the negedge, where ready and valid are settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    int   n;
    b = 1'b0;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b && n < 1000) begin
      @(negedge aclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid === 1'b1;
      rsp = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!b) n_errors++;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar, r;
    int   n;
    r = 1'b0;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r && n < 1000) begin
      @(negedge aclk);
      ar = arvalid && arready;
      r = rvalid === 1'b1;
      rdv = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!r) n_errors++;
  endtask
  // polls busy; a frame is far longer than one status read
  task automatic idle;
    int n;
    n = 0;
    do begin
      repeat (50) @(posedge aclk);
      rd(A_STATUS);
      n++;
    end while (rdv[0] !== 1'b0 && n < 200);
    if (rdv[0] !== 1'b0) n_errors++;
  endtask
  task automatic mwr(input logic [4:0] r, input logic [15:0] d);
    wr(A_CMD, {d, 7'h0, 1'b1, 3'h0, r});
    idle;
  endtask
  task automatic t_boot;
    int n;
    rd(A_CTRL);
    chk(rdv, 32'h0);
    wr(8'h40, 32'h1);
    chk(32'(rsp), 32'(RESP_SLVERR));
    rd(8'h40);
    chk({rdv[29:0], rsp}, 32'(RESP_SLVERR));
    wr(A_IRQ_MASK, 32'h3);
    wr(A_CTRL, 32'h3);
    n = 0;
    while (irq !== 1'b1 && n < 5000) begin
      @(negedge aclk);
      n++;
    end
    chk(32'(n >= 1900 && n < 5000), 32'h1);
    rd(A_STATUS);
    chk(32'(rdv[1:0]), 32'h2);
    rd(A_IRQ_STAT);
    chk(rdv, 32'h2);
    wr(A_IRQ_MASK, 32'h0);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0);
    wr(A_IRQ_STAT, 32'h2);
    wr(A_IRQ_MASK, 32'h3);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0);
  endtask
  task automatic t_mdio;
    logic [4:0]  regs [4] = '{REG_BMCR, REG_ADV, REG_GADV, REG_SKEW};
    logic [15:0] exps [4] = '{BMCR_RST, ADV_RST, GADV_RST, SKEW_RST};
    for (int i = 0; i < 4; i++) begin
      wr(A_CMD, {16'h0, 11'h0, regs[i]});
      idle;
      chk(32'(rdv[31:16]), 32'(exps[i]));
    end
    // a written zero in the last data bit must land as a zero
    mwr(REG_ADV, ADV_RST ^ 16'h0001);
    wr(A_CMD, {16'h0, 11'h0, REG_ADV});
    idle;
    chk(32'(rdv[31:16]), 32'(ADV_RST ^ 16'h0001));
    rd(A_IRQ_STAT);
    chk(rdv & 32'h1, 32'h1);
    mwr(REG_PAGE, PAGE_IER);
    wr(A_CMD, {16'h0, 11'h0, REG_IER});
    idle;
    chk(32'(rdv[31:16]), 32'(IER_RST_NEW));
    mwr(REG_PAGE, PAGE_LINK);
    wr(A_CMD, {16'h0, 11'h0, REG_PG_LINK});
    idle;
    chk(32'(rdv[31:16]), 32'h002c);
    wr(A_CMD, {16'h0, 11'h0, REG_PG_INT});
    idle;
    chk(32'(rdv[18]), 32'h1);
  endtask
  task automatic t_leds;
    logic off;
    off = 1'b0;
    chk(32'({link_up, led}), 32'hc);
    @(posedge aclk);
    trf <= 1'b1;
    repeat (60) begin
      @(negedge aclk);
      if (led[2] === 1'b0) off = 1'b1;
    end
    chk(32'(off), 32'h1);
    trf <= 1'b0;
    abil <= 3'b011;
    eee <= 1'b1;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk(32'({link_up, led}), 32'ha);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_boot;
    t_mdio;
    t_leds;
    stop_test;
  end
  initial begin
    #450000;
    n_errors++;
    stop_test;
  end
endmodule // ethernet_phy_bringup_management_bench
